// >>> core/mbs_pkg.sv
// Package of constants and types for the memory boundary-scan port.
package mbs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register widths.
    localparam int IR_W   = 3;
    localparam int ID_W   = 32;
    localparam int BSR_W  = 109;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction codes.
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;

    // Fixed pattern captured into the instruction shifter.
    localparam logic [2:0] IR_CAPTURE = 3'h1;

    // Reset values.
    localparam logic [2:0] IR_RESET   = INS_IDCODE;
    localparam logic       ID_FIX_BIT = 1'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Controller states, Gray steps along reset, idle and the DR path.
    typedef enum logic [3:0] {
        ST_RESET    = 4'h0,
        ST_IDLE     = 4'h1,
        ST_SEL_DR   = 4'h3,
        ST_CAP_DR   = 4'h2,
        ST_SHIFT_DR = 4'h6,
        ST_EXIT1_DR = 4'h7,
        ST_PAUSE_DR = 4'h5,
        ST_EXIT2_DR = 4'h4,
        ST_UPD_DR   = 4'hc,
        ST_SEL_IR   = 4'hd,
        ST_CAP_IR   = 4'hf,
        ST_SHIFT_IR = 4'he,
        ST_EXIT1_IR = 4'ha,
        ST_PAUSE_IR = 4'hb,
        ST_EXIT2_IR = 4'h9,
        ST_UPD_IR   = 4'h8
    } mbs_state_t;

endpackage

// >>> core/mbs_tap.sv
// Boundary-scan test access port of the memory, clocked by the test clock.
`timescale 1ns/1ps
// Overview of operation
// - Only extest, idcode, sample and bypass supported.
// - Inputs on test clock rise, output on fall.
// - State and instruction pick the serial register.
// - Five mode-select highs force logic reset.
// - Power-up reset forces controller to logic reset.
// - Instruction takes effect on update, loads when connected.
// - Logic reset and power-up load idcode instruction.
// - Bypass is one shift stage.
// - Idcode captures the 32-bit identification code.
// - Identification register shifts during shift-DR.
// - Boundary captures I/O ring, then shifts.
// - Extest and sample both select boundary register.
// - Each boundary cell maps to fixed ring bit.
//
// Design notes.
//
// Clocking and domains.
// The port has two clock domains. The test clock domain holds the controller,
// the instruction register, the three data registers and the output stage.
// The core clock domain only keeps a snapshot of the I/O ring for capture.
// Mode select and data in are sampled by the test clock, which launches them
// from the far side, so they are not passed through extra flip-flops.
//
// Ring snapshot crossing.
// The ring is wide, so it is never sampled bit by bit across the boundary.
// The core side loads a holding register and flips a request toggle.
// The test side synchronises the toggle in two stages and a third stage
// detects the change; only then is the held word copied into the shadow.
// The held word stays still while a request is open, so no bit can tear.
// The acknowledge toggle returns through two core clock stages.
// Capture-DR loads the shadow, so the captured ring is a few cycles old.
// A user must keep the ring steady across that delay for exact capture.
// The handshake only advances while the test clock runs; a stopped test
// clock leaves the last snapshot in the shadow until scanning resumes.
//
// Reset.
// The power-up reset clears the core side at once. For the test side it
// asserts at once and releases after two test clock rises, so the release
// never lands close to a test clock edge. The test clock must run for two
// rises after power-up before the controller leaves its reset state.
// Without a power-up event the only way back to logic reset is five rises
// with mode select high, which works from every one of the sixteen states.
//
// Instruction register.
// The instruction shifter is separate from the active instruction, so a
// scan in progress never disturbs the register that is connected. The
// active instruction changes only on the rise that leaves Update-IR, or on a rise in logic reset.
// Capture-IR loads the fixed pattern so a controller can check the chain.
// Unknown instruction codes connect the bypass stage.
//
// Data registers.
// The bypass stage captures zero and delays data by one test clock.
// The identification word is rebuilt from parameters on every Capture-DR with idcode selected.
// Extest and sample both capture and shift the boundary register; this
// port has no output cells, so extest drives nothing onto the ring.
//
// Serial output.
// The output bit and its enable are registered on the falling edge, half a
// period after the rise that moved the controller, so the far side can take
// the bit on the next rise with half a period of margin.
// Outside the two shift states the output is held low and not enabled.
module mbs_tap #(
    parameter logic [3:0]  ID_REVISION = 4'h0,   // Arbitrary value.
    parameter logic [15:0] ID_PART     = 16'h0123, // Arbitrary value.
    parameter logic [10:0] ID_VENDOR   = 11'h055, // Arbitrary value.
    parameter int          RING_W      = mbs_pkg::BSR_W
) (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic [RING_W-1:0] io_ring,
    input  wire logic              tck,
    input  wire logic              tms,
    input  wire logic              tdi,
    output logic                   tdo,
    output logic                   tdo_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check on the boundary length.
    if (RING_W < 2) begin : g_bad_ring
        $error("Boundary register must hold at least two cells.");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core-side state: snapshot of the ring and the request toggle.
    typedef struct packed {
        logic [RING_W-1:0] hold;
        logic              req;
        logic              ack_s1;
        logic              ack_s2;
    } mbs_core_t;

    // Test-clock-side state.
    typedef struct packed {
        mbs_pkg::mbs_state_t st;
        logic [2:0]          ir;
        logic [2:0]          ir_sh;
        logic [31:0]         id_sh;
        logic                byp;
        logic [RING_W-1:0]   bsr;
        logic [RING_W-1:0]   shadow;
        logic                ack;
        logic                req_s1;
        logic                req_s2;
        logic                req_s3;
    } mbs_tck_t;

    // Falling-edge output stage.
    typedef struct packed {
        logic tdo;
        logic oe;
    } mbs_out_t;

    mbs_core_t c_q;
    mbs_core_t next_c;
    mbs_tck_t  t_q;
    mbs_tck_t  next_t;
    mbs_out_t  o_q;
    mbs_out_t  next_o;
    logic      trst_s1;
    logic      trst_n;
    logic      ser_bit;
    logic      shifting;

    ////////////////////////////////////////////////////////////////////////////
    // Controller next state from mode select.
    function automatic mbs_pkg::mbs_state_t mbs_next_state(
        input mbs_pkg::mbs_state_t s,
        input logic                m
    );
        mbs_pkg::mbs_state_t n;
        case (s)
            mbs_pkg::ST_RESET: begin
                n = m ? mbs_pkg::ST_RESET : mbs_pkg::ST_IDLE;
            end
            mbs_pkg::ST_IDLE: begin
                n = m ? mbs_pkg::ST_SEL_DR : mbs_pkg::ST_IDLE;
            end
            mbs_pkg::ST_SEL_DR: begin
                n = m ? mbs_pkg::ST_SEL_IR : mbs_pkg::ST_CAP_DR;
            end
            mbs_pkg::ST_CAP_DR: begin
                n = m ? mbs_pkg::ST_EXIT1_DR : mbs_pkg::ST_SHIFT_DR;
            end
            mbs_pkg::ST_SHIFT_DR: begin
                n = m ? mbs_pkg::ST_EXIT1_DR : mbs_pkg::ST_SHIFT_DR;
            end
            mbs_pkg::ST_EXIT1_DR: begin
                n = m ? mbs_pkg::ST_UPD_DR : mbs_pkg::ST_PAUSE_DR;
            end
            mbs_pkg::ST_PAUSE_DR: begin
                n = m ? mbs_pkg::ST_EXIT2_DR : mbs_pkg::ST_PAUSE_DR;
            end
            mbs_pkg::ST_EXIT2_DR: begin
                n = m ? mbs_pkg::ST_UPD_DR : mbs_pkg::ST_SHIFT_DR;
            end
            mbs_pkg::ST_UPD_DR: begin
                n = m ? mbs_pkg::ST_SEL_DR : mbs_pkg::ST_IDLE;
            end
            mbs_pkg::ST_SEL_IR: begin
                n = m ? mbs_pkg::ST_RESET : mbs_pkg::ST_CAP_IR;
            end
            mbs_pkg::ST_CAP_IR: begin
                n = m ? mbs_pkg::ST_EXIT1_IR : mbs_pkg::ST_SHIFT_IR;
            end
            mbs_pkg::ST_SHIFT_IR: begin
                n = m ? mbs_pkg::ST_EXIT1_IR : mbs_pkg::ST_SHIFT_IR;
            end
            mbs_pkg::ST_EXIT1_IR: begin
                n = m ? mbs_pkg::ST_UPD_IR : mbs_pkg::ST_PAUSE_IR;
            end
            mbs_pkg::ST_PAUSE_IR: begin
                n = m ? mbs_pkg::ST_EXIT2_IR : mbs_pkg::ST_PAUSE_IR;
            end
            mbs_pkg::ST_EXIT2_IR: begin
                n = m ? mbs_pkg::ST_UPD_IR : mbs_pkg::ST_SHIFT_IR;
            end
            mbs_pkg::ST_UPD_IR: begin
                n = m ? mbs_pkg::ST_SEL_DR : mbs_pkg::ST_IDLE;
            end
            default: begin
                n = mbs_pkg::ST_RESET;
            end
        endcase
        return n;
    endfunction

    // True when the instruction routes the boundary register.
    function automatic logic mbs_is_bsr(input logic [2:0] i);
        return (i == mbs_pkg::INS_EXTEST) || (i == mbs_pkg::INS_SAMPLE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Core side: offer a fresh ring snapshot whenever the last was taken.
    always_comb begin
        next_c        = c_q;
        next_c.ack_s1 = t_q.ack;
        next_c.ack_s2 = c_q.ack_s1;
        if (c_q.ack_s2 == c_q.req) begin
            next_c.hold = io_ring;
            next_c.req  = ~c_q.req;
        end
    end

    // Core-side registers.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            c_q <= '0;
        end else begin
            c_q <= next_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-up reset for the test clock domain; release is synchronised.
    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            trst_s1 <= 1'b0;
            trst_n  <= 1'b0;
        end else begin
            trst_s1 <= 1'b1;
            trst_n  <= trst_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test clock side: controller, instruction and data registers.
    always_comb begin
        next_t        = t_q;
        next_t.req_s1 = c_q.req;
        next_t.req_s2 = t_q.req_s1;
        next_t.req_s3 = t_q.req_s2;
        // A new snapshot has arrived; keep it and acknowledge.
        if (t_q.req_s2 != t_q.req_s3) begin
            next_t.shadow = c_q.hold;
            next_t.ack    = t_q.req_s2;
        end
        next_t.st = mbs_next_state(t_q.st, tms);
        case (t_q.st)
            mbs_pkg::ST_RESET: begin
                next_t.ir = mbs_pkg::IR_RESET;
            end
            mbs_pkg::ST_CAP_IR: begin
                next_t.ir_sh = mbs_pkg::IR_CAPTURE;
            end
            mbs_pkg::ST_SHIFT_IR: begin
                next_t.ir_sh = {tdi, t_q.ir_sh[2:1]};
            end
            mbs_pkg::ST_UPD_IR: begin
                next_t.ir = t_q.ir_sh;
            end
            mbs_pkg::ST_CAP_DR: begin
                next_t.byp = 1'b0;
                if (t_q.ir == mbs_pkg::INS_IDCODE) begin
                    next_t.id_sh = {ID_REVISION, ID_PART, ID_VENDOR, mbs_pkg::ID_FIX_BIT};
                end
                if (mbs_is_bsr(t_q.ir)) begin
                    next_t.bsr = t_q.shadow;
                end
            end
            mbs_pkg::ST_SHIFT_DR: begin
                if (t_q.ir == mbs_pkg::INS_IDCODE) begin
                    next_t.id_sh = {tdi, t_q.id_sh[31:1]};
                end else if (mbs_is_bsr(t_q.ir)) begin
                    next_t.bsr = {tdi, t_q.bsr[RING_W-1:1]};
                end else begin
                    next_t.byp = tdi;
                end
            end
            default: begin
                next_t.ir = t_q.ir;
            end
        endcase
    end

    // Test clock registers, sampled on the rising edge.
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            t_q    <= '0;
            t_q.st <= mbs_pkg::ST_RESET;
            t_q.ir <= mbs_pkg::IR_RESET;
        end else begin
            t_q <= next_t;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial path selection from state and instruction.
    always_comb begin
        shifting = 1'b0;
        ser_bit  = t_q.byp;
        if (t_q.st == mbs_pkg::ST_SHIFT_IR) begin
            shifting = 1'b1;
            ser_bit  = t_q.ir_sh[0];
        end else if (t_q.st == mbs_pkg::ST_SHIFT_DR) begin
            shifting = 1'b1;
            if (t_q.ir == mbs_pkg::INS_IDCODE) begin
                ser_bit = t_q.id_sh[0];
            end else if (mbs_is_bsr(t_q.ir)) begin
                ser_bit = t_q.bsr[0];
            end else begin
                ser_bit = t_q.byp;
            end
        end
    end

    // Output stage values.
    always_comb begin
        next_o     = o_q;
        next_o.oe  = shifting;
        next_o.tdo = shifting ? ser_bit : 1'b0;
    end

    // Serial output changes only on the falling edge.
    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            o_q <= '0;
        end else begin
            o_q <= next_o;
        end
    end

    // Outputs straight from the falling-edge flops.
    assign tdo    = o_q.tdo;
    assign tdo_oe = o_q.oe;

endmodule // mbs_tap

// >>> tb/mbs_jtag_host.sv
// Behavioural scan controller that drives the test clock, mode select and data in.
`timescale 1ns/1ps
module mbs_jtag_host (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input wire logic  tdo
);
    // The test clock stands low between calls.
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
    end

    // One test clock period; output is taken at the rise, while it is settled.
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #7.5 tck = 1'h1;
        o = tdo;
        #7.5 tck = 1'h0;
    endtask

    // Five high mode-select edges reach logic reset from anywhere.
    task automatic goto_reset();
        logic o;
        repeat (5) step(1'h1, 1'h0, o);
    endtask

    // Capture, shift n bits first bit first, update and park in idle.
    task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        logic o;
        dout = '0;
        step(1'h0, 1'h0, o);
        step(1'h1, 1'h0, o);
        if (ir) step(1'h1, 1'h0, o);
        step(1'h0, 1'h0, o);
        step(1'h0, 1'h0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'h1, 1'h0, o);
        step(1'h0, 1'h0, o);
    endtask
endmodule // mbs_jtag_host

// >>> tb/mbs_tap_props.sv
// Assertion checker for the boundary-scan port, bound to its top module.
`timescale 1ns/1ps
module mbs_tap_chk (
    input wire logic rst_b,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // All checks run on the test clock and rest while the power-up reset is low.
    default clocking cb @(posedge tck); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////
    // Mode-select walks: five highs, then from reset into a shift state.
    sequence s_rst; tms [*5]; endsequence
    sequence s_sdr; !tms ##1 tms ##1 !tms [*2]; endsequence
    sequence s_sir; !tms ##1 tms [*2] ##1 !tms [*2]; endsequence

    ////////////////////////////////////////
    // Properties on the serial output and its enable.
    a_five_reset: assert property (s_rst |-> ##1 !tdo_oe && !tdo)
        else $error("output active after reset walk");
    a_sdr_entry: assert property (s_rst ##1 s_sdr |-> ##1 tdo_oe && tdo)
        else $error("data shift did not start with code bit");
    a_sir_entry: assert property (s_rst ##1 s_sir |-> ##1 tdo_oe && tdo)
        else $error("instruction shift did not start with capture bit");
    a_oe_hold: assert property (tdo_oe && !tms |-> ##1 tdo_oe)
        else $error("output enable dropped inside shift");
    a_oe_drop: assert property (tdo_oe && tms |-> ##1 !tdo_oe)
        else $error("output enable held after shift exit");
    a_tdo_quiet: assert property (!tdo_oe |-> !tdo)
        else $error("serial output not low while disabled");
    a_oe_cause: assert property ($rose(tdo_oe) |-> !$past(tms))
        else $error("shift entered on high mode select");
    a_stay_off: assert property (!tdo_oe && tms |-> ##1 !tdo_oe)
        else $error("shift entered from a non-shift state on high select");
endmodule // mbs_tap_chk

bind mbs_tap mbs_tap_chk i_mbs_tap_chk (.rst_b(rst_b), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe));

// >>> tb/mbs_tap_tb.sv
// Self-checking testbench for the memory boundary-scan port.
`timescale 1ns/1ps
module mbs_tap_tb;
    localparam logic [31:0] ID = {4'h3, 16'h0abc, 11'h02a, 1'h1}; // Arbitrary code values.
    logic         core_clk   = 1'h0;
    logic         rst_b      = 1'h0;
    logic [108:0] io_ring    = '0;
    logic         tck;
    logic         tms;
    logic         tdi;
    logic         tdo;
    logic         tdo_oe;
    logic         tdo_pin;
    logic [127:0] q;
    int           fail_count = 0;
    int           n_tests    = 0;
    int           cyc        = 0;

    mbs_tap #(.ID_REVISION(4'h3), .ID_PART(16'h0abc), .ID_VENDOR(11'h02a)) i_mbs_tap (.core_clk(core_clk),
        .rst_b(rst_b), .io_ring(io_ring), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    mbs_jtag_host i_mbs_jtag_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));

    // Board pull-up: a released serial output reads high at the controller.
    assign tdo_pin = tdo_oe ? tdo : 1'h1;

    // Core clock and the hang limit.
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fail_count++;
            close_out();
        end
    end

    ////////////////////////////////////////
    // Shared tasks.
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic do_reset();
        logic o;
        @(posedge core_clk) rst_b <= 1'h0;
        repeat (11) i_mbs_jtag_host.step(1'h1, 1'h0, o);
        @(posedge core_clk) rst_b <= 1'h1;
        repeat (6) i_mbs_jtag_host.step(1'h1, 1'h0, o);
    endtask

    ////////////////////////////////////////
    // Scenarios.
    task automatic t_idcode();
        i_mbs_jtag_host.scan(1'h0, 32, '0, q);
        chk(q[31:0], ID);
        $display("idcode test done");
    endtask
    task automatic t_bypass();
        logic [2:0] c[2] = '{mbs_pkg::INS_BYPASS, 3'h2};
        foreach (c[i]) begin
            i_mbs_jtag_host.scan(1'h1, 3, c[i], q);
            chk(q[2:0], mbs_pkg::IR_CAPTURE);
            i_mbs_jtag_host.scan(1'h0, 8, 8'hb5, q);
            chk(q[7:0], 8'h6a);
        end
        $display("bypass test done");
    endtask
    task automatic t_ring();
        logic [2:0]   c[2] = '{mbs_pkg::INS_EXTEST, mbs_pkg::INS_SAMPLE};
        logic [108:0] p;
        foreach (c[i]) begin
            p = {3{36'h5a3c96f1e}} ^ i;
            p[108] = 1'h1;
            @(posedge core_clk) io_ring <= p;
            repeat (20) @(posedge core_clk);
            i_mbs_jtag_host.scan(1'h1, 3, c[i], q);
            i_mbs_jtag_host.scan(1'h0, 109, '0, q);
            chk(q[108:0], p);
        end
        $display("boundary test done");
    endtask
    task automatic t_five();
        i_mbs_jtag_host.scan(1'h1, 3, mbs_pkg::INS_BYPASS, q);
        i_mbs_jtag_host.goto_reset();
        #1 chk(tdo_oe, 1'h0);
        i_mbs_jtag_host.scan(1'h0, 32, '0, q);
        chk(q[31:0], ID);
        $display("five-high reset test done");
    endtask
    task automatic t_power();
        i_mbs_jtag_host.scan(1'h1, 3, mbs_pkg::INS_SAMPLE, q);
        do_reset();
        #1 chk({tdo_oe, tdo}, 2'h0);
        i_mbs_jtag_host.scan(1'h1, 3, mbs_pkg::INS_IDCODE, q);
        chk(q[2:0], mbs_pkg::IR_CAPTURE);
        i_mbs_jtag_host.scan(1'h0, 32, '0, q);
        chk(q[31:0], ID);
        $display("power-up reset test done");
    endtask

    // Main sequence.
    initial begin
        do_reset();
        t_idcode();
        t_bypass();
        t_ring();
        t_five();
        t_power();
        close_out();
    end
endmodule // mbs_tap_tb
